// >>> shared/dcpct_regs.vh
`ifndef DCPCT_REGS_VH
`define DCPCT_REGS_VH
// ==================================================================
// Register map, byte addresses on the APB bus.
// ==================================================================
`define DCPCT_OFS_GCTRL    12'h000
`define DCPCT_OFS_OUTCFG   12'h004
`define DCPCT_OFS_STATUS   12'h008
`define DCPCT_OFS_CH0      12'h020
`define DCPCT_OFS_CH1      12'h040
// Offsets inside one channel window.
`define DCPCT_CH_CTRL      5'h00
`define DCPCT_CH_IO        5'h04
`define DCPCT_CH_CNT       5'h08
`define DCPCT_CH_GRA       5'h0c
`define DCPCT_CH_GRB       5'h10
`define DCPCT_CH_GRC       5'h14
`define DCPCT_CH_GRD       5'h18
// ==================================================================
// Global control fields.
// ==================================================================
`define DCPCT_GC_START     1:0
`define DCPCT_GC_SYNC      2
`define DCPCT_GC_MODE      5:3
`define DCPCT_GC_BUF       7:6
`define DCPCT_GC_ADC_CREST 8
`define DCPCT_GC_ADC_TROUGH 9
// Operating modes.
`define DCPCT_MODE_TIMER   3'h0
`define DCPCT_MODE_PWM     3'h1
`define DCPCT_MODE_SPWM    3'h2
`define DCPCT_MODE_RSPWM   3'h3
`define DCPCT_MODE_CPWM    3'h4
// Channel control fields: count clock and clear source.
`define DCPCT_CC_CLK       2:0
`define DCPCT_CC_CLR       5:3
`define DCPCT_CLK_EXT      3'h6
// Compare actions and capture edges, per general register nibble.
`define DCPCT_ACT_LOW      2'h1
`define DCPCT_ACT_HIGH     2'h2
`define DCPCT_ACT_TOGGLE   2'h3
// ==================================================================
// Reset values and limits.
// ==================================================================
`define DCPCT_RST_GR       16'hffff
`define DCPCT_RST_CNT      16'h0000
`define DCPCT_CNT_MAX      16'hffff
`define DCPCT_DIV40_LAST   6'h27
`define DCPCT_NFLAGS       11
`endif

// >>> src/dcpct_timer.v
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dcpct_regs.vh"

module dcpct_timer (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [7:0]  channel_pin_in,
	output reg  [7:0]  channel_pin_out,
	output reg  [7:0]  channel_pin_oe,
	input  wire        output_disable_input,
	output reg         cma0_event,
	output reg         adc_trigger,
	output reg  [10:0] int_source
);

	// ==================================================================
	// Bus strobes and global registers.
	// ==================================================================
	reg  [15:0] gctrl_r;
	reg  [15:0] outcfg_r;
	reg  [11:0] status_r;
	reg  [7:0]  pin_s1_r;
	reg  [7:0]  pin_s2_r;
	reg  [7:0]  pin_d_r;
	reg         odis_s1_r;
	reg         odis_s2_r;
	reg  [4:0]  div_r;
	reg  [5:0]  div40_r;
	wire [7:0]  tick_src;
	wire [7:0]  hit_v;
	wire [7:0]  match_v;
	wire [1:0]  clr_v;
	wire [1:0]  cnt_wr_v;
	wire [31:0] cnt_v;
	wire [127:0] gr_v;
	wire [31:0] io_v;
	wire [63:0] rd_v;
	wire [1:0]  sel_v;
	wire [1:0]  map_v;
	wire [9:0]  ev_v;
	wire        udf;
	wire        peak0;
	wire        trough0;
	wire        apb_wr;
	wire        apb_setup;
	wire [2:0]  mode;
	wire        cpwm;
	reg  [31:0] rdata;
	reg         mapped;
	reg  [7:0]  pin_nxt;
	reg  [16:0] dead_sum;
	integer     k;

	assign apb_wr    = psel & penable & pwrite;
	assign apb_setup = psel & ~penable;
	assign mode      = gctrl_r[`DCPCT_GC_MODE];
	assign cpwm      = (mode == `DCPCT_MODE_CPWM);

	// Pins and the disable input cross in through two flops each; edges are
	// detected on the second stage only.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r  <= 8'h00;
			pin_s2_r  <= 8'h00;
			pin_d_r   <= 8'h00;
			odis_s1_r <= 1'b0;
			odis_s2_r <= 1'b0;
		end else begin
			pin_s1_r  <= channel_pin_in;
			pin_s2_r  <= pin_s1_r;
			pin_d_r   <= pin_s2_r;
			odis_s1_r <= output_disable_input;
			odis_s2_r <= odis_s1_r;
		end
	end

	// Free-running prescalers; a tick is a one-cycle enable, not a new clock.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r   <= 5'h00;
			div40_r <= 6'h00;
		end else begin
			div_r   <= div_r + 5'h01;
			div40_r <= (div40_r == `DCPCT_DIV40_LAST) ? 6'h00 : div40_r + 6'h01;
		end
	end

	// Tick per clock select code; code 6 is a rising edge on pin A of channel 0.
	assign tick_src = {1'b0, pin_s2_r[0] & ~pin_d_r[0], div40_r == `DCPCT_DIV40_LAST,
		&div_r, &div_r[2:0], &div_r[1:0], div_r[0], 1'b1};

	// ==================================================================
	// Channels.
	// ==================================================================
	genvar i, j;
	generate
	for (i = 0; i < 2; i = i + 1) begin : ch
		reg  [15:0] cnt_r;
		reg  [15:0] gra_r;
		reg  [15:0] grb_r;
		reg  [15:0] grc_r;
		reg  [15:0] grd_r;
		reg  [7:0]  ctrl_r;
		reg  [15:0] io_r;
		reg         down_r;
		wire [11:0] base = (i == 0) ? `DCPCT_OFS_CH0 : `DCPCT_OFS_CH1;
		wire [4:0]  ro = paddr[4:0];
		wire        sel = (paddr[11:5] == base[11:5]);
		wire        wr = apb_wr & sel;
		wire        tick = gctrl_r[i] & tick_src[ctrl_r[`DCPCT_CC_CLK]];
		wire        bufd = gctrl_r[6 + i];
		wire [3:0]  capm = {io_r[12], io_r[8], io_r[4], io_r[0]};
		wire [3:0]  eq = {cnt_r == grd_r, cnt_r == grc_r, cnt_r == grb_r, cnt_r == gra_r};
		wire [3:0]  match = {4{tick}} & eq & ~capm;
		wire [3:0]  rise = pin_s2_r[4*i +: 4] & ~pin_d_r[4*i +: 4];
		wire [3:0]  fall = ~pin_s2_r[4*i +: 4] & pin_d_r[4*i +: 4];
		wire [3:0]  cap;
		wire [3:0]  hit = match | cap;
		wire [2:0]  cs = ctrl_r[`DCPCT_CC_CLR];
		wire [2:0]  csm = cs - 3'h1;
		wire        clr = clr_v[i] | (gctrl_r[`DCPCT_GC_SYNC] & (|clr_v));
		wire        cnt_ld = cnt_wr_v[i] | (gctrl_r[`DCPCT_GC_SYNC] & (|cnt_wr_v));
		wire        peak = cpwm & ~down_r & tick & (cnt_r >= gra_r);
		wire        trough = cpwm & down_r & tick & (cnt_r == 16'h0000);
		wire        ovf = tick & ~cpwm & (cnt_r == `DCPCT_CNT_MAX);

		for (j = 0; j < 4; j = j + 1) begin : cp
			// Capture only in timer mode; the pins are outputs in the PWM modes.
			assign cap[j] = capm[j] & (mode == `DCPCT_MODE_TIMER) &
				((io_r[4*j+1] & rise[j]) | (io_r[4*j+2] & fall[j]));
		end

		// Clear source picked from the channel's own four registers.
		assign clr_v[i]   = (cs != 3'h0) & (cs < 3'h5) & hit[csm[1:0]] & ~cpwm;
		assign cnt_wr_v[i] = wr & (ro == `DCPCT_CH_CNT);
		assign hit_v[4*i +: 4]   = hit;
		assign match_v[4*i +: 4] = match;
		assign ev_v[5*i +: 5]    = {ovf, hit};
		assign cnt_v[16*i +: 16] = cnt_r;
		assign gr_v[64*i +: 64]  = {grd_r, grc_r, grb_r, gra_r};
		assign io_v[16*i +: 16]  = io_r;
		assign sel_v[i] = sel;
		assign map_v[i] = (ro <= `DCPCT_CH_GRD) & (ro[1:0] == 2'h0);
		assign rd_v[32*i +: 32] = {16'h0000,
			(ro == `DCPCT_CH_CTRL) ? {8'h00, ctrl_r} :
			(ro == `DCPCT_CH_IO)   ? io_r :
			(ro == `DCPCT_CH_CNT)  ? cnt_r :
			(ro == `DCPCT_CH_GRA)  ? gra_r :
			(ro == `DCPCT_CH_GRB)  ? grb_r :
			(ro == `DCPCT_CH_GRC)  ? grc_r :
			(ro == `DCPCT_CH_GRD)  ? grd_r : 16'h0000};
		if (i == 0) begin : t0
			assign peak0   = peak;
			assign trough0 = trough;
		end else begin : t1
			assign udf = trough;
		end

		// Counter: bus load wins, then clear, then counting; complementary
		// mode runs a triangle between zero and register A.
		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_r  <= `DCPCT_RST_CNT;
				down_r <= 1'b0;
			end else if (cnt_ld) begin
				cnt_r  <= pwdata[15:0];
				down_r <= 1'b0;
			end else if (cpwm) begin
				if (peak) begin
					down_r <= 1'b1;
					cnt_r  <= cnt_r - 16'h0001;
				end else if (trough) begin
					down_r <= 1'b0;
					cnt_r  <= cnt_r + 16'h0001;
				end else if (tick) begin
					cnt_r <= down_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
				end
			end else if (clr) begin
				cnt_r <= `DCPCT_RST_CNT;
			end else if (tick) begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end

		// General registers: buffer moves, then captures, then the bus last.
		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				gra_r  <= `DCPCT_RST_GR;
				grb_r  <= `DCPCT_RST_GR;
				grc_r  <= `DCPCT_RST_GR;
				grd_r  <= `DCPCT_RST_GR;
				ctrl_r <= 8'h00;
				io_r   <= 16'h0000;
			end else begin
				if (bufd & (clr | trough)) begin
					if (!capm[0]) gra_r <= grc_r;
					if (!capm[1]) grb_r <= grd_r;
				end
				if (cap[0]) begin
					gra_r <= cnt_r;
					if (bufd) grc_r <= gra_r;
				end
				if (cap[1]) begin
					grb_r <= cnt_r;
					if (bufd) grd_r <= grb_r;
				end
				if (cap[2] & ~bufd) grc_r <= cnt_r;
				if (cap[3] & ~bufd) grd_r <= cnt_r;
				if (wr & (ro == `DCPCT_CH_GRA)) gra_r <= pwdata[15:0];
				if (wr & (ro == `DCPCT_CH_GRB)) grb_r <= pwdata[15:0];
				if (wr & (ro == `DCPCT_CH_GRC)) grc_r <= pwdata[15:0];
				if (wr & (ro == `DCPCT_CH_GRD)) grd_r <= pwdata[15:0];
				if (wr & (ro == `DCPCT_CH_CTRL)) ctrl_r <= pwdata[7:0];
				if (wr & (ro == `DCPCT_CH_IO)) io_r <= pwdata[15:0];
			end
		end
	end
	endgenerate

	// ==================================================================
	// Pin waveforms.
	// ==================================================================
	// Before counting starts every pin shows its programmed initial level.
	always @* begin
		pin_nxt  = channel_pin_out;
		dead_sum = 17'h00000;
		if (gctrl_r[`DCPCT_GC_START] == 2'h0) begin
			pin_nxt = outcfg_r[7:0];
		end else begin
			case (mode)
			`DCPCT_MODE_TIMER: begin
				// Pin k owns nibble k of the joined IO words, so one index serves both.
				for (k = 0; k < 8; k = k + 1) begin
					if (match_v[k]) begin
						if (io_v[4*k+1 +: 2] == `DCPCT_ACT_LOW) pin_nxt[k] = 1'b0;
						else if (io_v[4*k+1 +: 2] == `DCPCT_ACT_HIGH) pin_nxt[k] = 1'b1;
						else if (io_v[4*k+1 +: 2] == `DCPCT_ACT_TOGGLE)
							pin_nxt[k] = ~channel_pin_out[k];
					end
				end
			end
			`DCPCT_MODE_PWM: begin
				// A sets the period; B, C, D flip away from the initial level.
				for (k = 1; k < 8; k = k + 1) begin
					if (k != 4) begin
						if (match_v[k]) pin_nxt[k] = ~outcfg_r[k];
						else if (match_v[k - (k % 4)]) pin_nxt[k] = outcfg_r[k];
					end
				end
			end
			`DCPCT_MODE_SPWM: begin
				// The counter phase is masked by the normal one, so overlap is impossible.
				pin_nxt[0] = (cnt_v[15:0] >= gr_v[15:0]) & (cnt_v[15:0] < gr_v[31:16]);
				pin_nxt[4] = (cnt_v[15:0] >= gr_v[79:64]) & (cnt_v[15:0] < gr_v[95:80])
					& ~pin_nxt[0];
			end
			`DCPCT_MODE_RSPWM: begin
				for (k = 1; k < 4; k = k + 1) begin
					if (match_v[k]) pin_nxt[k] = 1'b0;
					else if (match_v[0]) pin_nxt[k] = 1'b1;
					pin_nxt[k + 4] = ~pin_nxt[k];
				end
			end
			`DCPCT_MODE_CPWM: begin
				// Channel 1 register A is the dead time between the two phases.
				for (k = 1; k < 4; k = k + 1) begin
					dead_sum = {1'b0, gr_v[16*k +: 16]} + {1'b0, gr_v[79:64]};
					pin_nxt[k]     = ({1'b0, cnt_v[15:0]} > dead_sum);
					pin_nxt[k + 4] = (cnt_v[15:0] < gr_v[16*k +: 16]);
				end
			end
			default: ;
			endcase
		end
	end

	// Outputs, enables, event pulses and sticky flags.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_pin_out <= 8'h00;
			channel_pin_oe  <= 8'h00;
			cma0_event      <= 1'b0;
			adc_trigger     <= 1'b0;
			int_source      <= 11'h000;
			status_r        <= 12'h000;
		end else begin
			channel_pin_out <= pin_nxt;
			channel_pin_oe  <= outcfg_r[15:8] & {8{~(status_r[11] | odis_s2_r)}};
			cma0_event      <= match_v[0];
			adc_trigger     <= (gctrl_r[`DCPCT_GC_ADC_CREST] & peak0) |
				(gctrl_r[`DCPCT_GC_ADC_TROUGH] & trough0);
			int_source      <= {udf, ev_v};
			// A new event in the clearing cycle keeps its flag set.
			status_r <= ((apb_wr & (paddr == `DCPCT_OFS_STATUS)) ?
				(status_r & ~pwdata[11:0]) : status_r) | {odis_s2_r, udf, ev_v};
		end
	end

	// ==================================================================
	// APB slave: zero wait states, data captured in the setup cycle.
	// ==================================================================
	always @* begin
		rdata  = 32'h00000000;
		mapped = 1'b1;
		if (paddr == `DCPCT_OFS_GCTRL) begin
			rdata = {16'h0000, gctrl_r};
		end else if (paddr == `DCPCT_OFS_OUTCFG) begin
			rdata = {16'h0000, outcfg_r};
		end else if (paddr == `DCPCT_OFS_STATUS) begin
			rdata = {20'h00000, status_r};
		end else if (sel_v[0] & map_v[0]) begin
			rdata = rd_v[31:0];
		end else if (sel_v[1] & map_v[1]) begin
			rdata = rd_v[63:32];
		end else begin
			mapped = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata   <= 32'h00000000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			gctrl_r  <= 16'h0000;
			outcfg_r <= 16'h0000;
		end else begin
			pready <= 1'b1;
			if (apb_setup) begin
				prdata  <= pwrite ? 32'h00000000 : rdata;
				pslverr <= ~mapped;
			end
			if (apb_wr & (paddr == `DCPCT_OFS_GCTRL)) gctrl_r <= pwdata[15:0];
			if (apb_wr & (paddr == `DCPCT_OFS_OUTCFG)) outcfg_r <= pwdata[15:0];
		end
	end

endmodule // dcpct_timer
`default_nettype wire

// >>> test/dcpct_timer_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port checker for the timer unit.
module dcpct_timer_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  channel_pin_oe,
	input wire logic        output_disable_input,
	input wire logic        cma0_event,
	input wire logic        adc_trigger,
	input wire logic [10:0] int_source
);
	// All checks share the bus clock, so reset disables them all at once.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	evt_pulse_a: assert property (cma0_event |=> !cma0_event)
		else $error("match event longer than one cycle");
	evt_flag_a: assert property (cma0_event |-> int_source[0])
		else $error("match event without its source flag");
	ovf_pulse_a: assert property (int_source[4] |=> !int_source[4])
		else $error("overflow source held too long");
	adc_pulse_a: assert property (adc_trigger |=> !adc_trigger)
		else $error("conversion trigger held too long");
	// Two sync flops plus the enable register give three cycles.
	odis_off_a: assert property (output_disable_input [*3] |=> channel_pin_oe == 8'h00)
		else $error("outputs still enabled while disabled");
	ready_acc_a: assert property (psel && penable |-> pready)
		else $error("no ready in access phase");
	unmap_err_a: assert property (psel && !penable && paddr == 12'hffc |=> pslverr)
		else $error("unmapped access not refused");
	map_ok_a: assert property (psel && !penable && paddr == 12'h000 |=> !pslverr)
		else $error("mapped access refused");
endmodule // dcpct_timer_checker

bind dcpct_timer dcpct_timer_checker dcpct_timer_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .channel_pin_oe(channel_pin_oe),
	.output_disable_input(output_disable_input), .cma0_event(cma0_event),
	.adc_trigger(adc_trigger), .int_source(int_source));
`default_nettype wire

// >>> test/dcpct_far_end.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Pin loads and event link seen from outside the unit.
module dcpct_far_end (
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic [7:0]   pin_out,
	input wire logic [7:0]   pin_oe,
	input wire logic [7:0]   ext_level,
	output logic [7:0]       pin_in,
	input wire logic         cma0_event,
	input wire logic         adc_trigger,
	output logic [15:0]      ev_count,
	output logic [15:0]      ev_gap,
	output logic [15:0]      hi_width,
	output logic [15:0]      adc_count
);
	logic [15:0] cyc_r, last_r, run_r;

	// A released pin shows the outside source, never the last driven level.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);

	// Event link counts events and their spacing; pin B load times its high phase.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cyc_r, last_r, run_r, ev_count, ev_gap, hi_width, adc_count} <= '0;
		end else begin
			cyc_r <= cyc_r + 16'h0001;
			if (cma0_event) begin
				ev_count <= ev_count + 16'h0001;
				ev_gap <= cyc_r - last_r;
				last_r <= cyc_r;
			end
			if (pin_in[1])
				run_r <= run_r + 16'h0001;
			else if (run_r != 16'h0000) begin
				hi_width <= run_r;
				run_r <= 16'h0000;
			end
			if (adc_trigger)
				adc_count <= adc_count + 16'h0001;
		end
	end
endmodule // dcpct_far_end
`default_nettype wire

// >>> test/test_dual_channel_pwm_capture_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "dcpct_regs.vh"
// ==========================================================
// Self-checking bench for the timer unit.
module test_dual_channel_pwm_capture_timer;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, seed = 32'd73813;
	logic        odi = 1'b0, er;
	logic [7:0]  ext = 8'h00;
	wire  [31:0] prdata;
	wire         pready, pslverr, cma0_event, adc_trigger;
	wire  [7:0]  pin_out, pin_oe, pin_in;
	wire  [10:0] int_source;
	wire  [15:0] ev_count, ev_gap, hi_width, adc_count;
	logic [15:0] tbl [3];
	int          dv [6] = '{1, 2, 4, 8, 32, 40};
	int          n_errors = 0, total_checks = 0;

	always #50 pclk = ~pclk;

	dcpct_timer dcpct_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_pin_in(pin_in),
		.channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .output_disable_input(odi),
		.cma0_event(cma0_event), .adc_trigger(adc_trigger), .int_source(int_source));
	dcpct_far_end dcpct_far_end_inst (.pclk(pclk), .presetn(presetn), .pin_out(pin_out),
		.pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in), .cma0_event(cma0_event),
		.adc_trigger(adc_trigger), .ev_count(ev_count), .ev_gap(ev_gap),
		.hi_width(hi_width), .adc_count(adc_count));

	// Random source, register addresses and expected pin levels.
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function logic [11:0] ca(input int ch, input logic [4:0] o);
		return (ch == 0 ? `DCPCT_OFS_CH0 : `DCPCT_OFS_CH1) + {7'h00, o};
	endfunction
	function logic exp_pin(input logic [1:0] a, input logic s);
		return a == `DCPCT_ACT_LOW ? 1'b0 : a == `DCPCT_ACT_HIGH ? 1'b1 : ~s;
	endfunction

	// One APB transfer; ready and read data are taken at the rising edge.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (pready !== 1'b1) begin
			n_errors++;
			$display("wrong value at %0t: no ready from the slave", $time);
		end
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task wait_ev;
		int n;
		logic [15:0] c;
		c = ev_count;
		n = 0;
		while (ev_count === c && n < 500) begin @(posedge pclk); n++; end
		chk(n < 500, 1'b1);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Watchdog sized well above the longest sequence.
	initial begin
		repeat (60000) @(posedge pclk);
		n_errors++;
		complete_run;
	end

	// Main sequence.
	initial begin
		int i;
		logic [15:0] r;
		logic s;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rchk(ca(0, `DCPCT_CH_GRA), 32'h0000ffff);
		rchk(ca(1, `DCPCT_CH_CNT), 32'h0);
		seed = lfsr(seed);
		r = seed[15:0];
		apb(1'b1, ca(1, `DCPCT_CH_GRD), {16'h0, r});
		rchk(ca(1, `DCPCT_CH_GRD), {16'h0, r});
		rchk(12'hffc, 32'h0);
		chk(er, 1'b1);
		// One counter write loads both channels in synchronous mode.
		apb(1'b1, `DCPCT_OFS_GCTRL, 32'h4);
		apb(1'b1, ca(0, `DCPCT_CH_CNT), {16'h0, ~r});
		rchk(ca(1, `DCPCT_CH_CNT), {16'h0, ~r});
		apb(1'b1, `DCPCT_OFS_GCTRL, 32'h0);
		// Count rate for every internal divisor over about 403 cycles.
		for (i = 0; i < 6; i++) begin
			apb(1'b1, ca(1, `DCPCT_CH_CTRL), 32'(i));
			apb(1'b1, ca(1, `DCPCT_CH_CNT), 32'h0);
			apb(1'b1, `DCPCT_OFS_GCTRL, 32'h2);
			repeat (400) @(posedge pclk);
			apb(1'b1, `DCPCT_OFS_GCTRL, 32'h0);
			apb(1'b0, ca(1, `DCPCT_CH_CNT), 32'h0);
			chk(rd[15:0] + 2 >= 403 / dv[i] && rd[15:0] <= 403 / dv[i] + 2, 1'b1);
		end
		// Each compare action on channel 1 pin A, from a random initial level.
		apb(1'b1, ca(1, `DCPCT_CH_CTRL), 32'h0);
		apb(1'b1, ca(1, `DCPCT_CH_GRA), 32'h5);
		for (i = 1; i < 4; i++) begin
			seed = lfsr(seed);
			s = seed[0];
			apb(1'b1, ca(1, `DCPCT_CH_CNT), 32'h0);
			apb(1'b1, ca(1, `DCPCT_CH_IO), 32'(i * 2));
			apb(1'b1, `DCPCT_OFS_OUTCFG, {19'h00080, s, 4'h0});
			// The new initial level reaches the pin one edge after the write.
			@(posedge pclk);
			@(negedge pclk);
			chk(pin_out[4], s);
			apb(1'b1, `DCPCT_OFS_GCTRL, 32'h2);
			repeat (20) @(posedge pclk);
			apb(1'b1, `DCPCT_OFS_GCTRL, 32'h0);
			@(negedge pclk);
			chk(pin_out[4], exp_pin(i[1:0], s));
		end
		// Overflow of channel 0 leaves its sticky flag.
		apb(1'b1, `DCPCT_OFS_STATUS, 32'hfff);
		apb(1'b1, ca(0, `DCPCT_CH_CTRL), 32'h0);
		apb(1'b1, ca(0, `DCPCT_CH_CNT), 32'hfff0);
		apb(1'b1, `DCPCT_OFS_GCTRL, 32'h1);
		repeat (30) @(posedge pclk);
		apb(1'b1, `DCPCT_OFS_GCTRL, 32'h0);
		apb(1'b0, `DCPCT_OFS_STATUS, 32'h0);
		chk(rd[4], 1'b1);
		// Capture on register C: rising, falling, then both edges; the first
		// change is the wrong edge except in the both-edges pass.
		for (i = 0; i < 3; i++) begin
			s = (i != 1);
			ext[2] <= s;
			apb(1'b1, ca(0, `DCPCT_CH_IO), 32'h300 + 32'(i) * 32'h200);
			apb(1'b1, ca(0, `DCPCT_CH_GRC), 32'hffff);
			apb(1'b1, `DCPCT_OFS_GCTRL, 32'h1);
			ext[2] <= ~s;
			repeat (6) @(posedge pclk);
			apb(1'b0, ca(0, `DCPCT_CH_GRC), 32'h0);
			chk(rd[15:0] == 16'hffff, i < 2);
			apb(1'b0, ca(0, `DCPCT_CH_CNT), 32'h0);
			r = rd[15:0];
			ext[2] <= s;
			repeat (6) @(posedge pclk);
			apb(1'b0, ca(0, `DCPCT_CH_GRC), 32'h0);
			chk(rd[15:0] > r && rd[15:0] < r + 16'h10, 1'b1);
			apb(1'b1, `DCPCT_OFS_GCTRL, 32'h0);
		end
		// Output disable is sticky until its status bit is cleared.
		apb(1'b1, `DCPCT_OFS_OUTCFG, 32'h0f00);
		odi <= 1'b1;
		repeat (6) @(posedge pclk);
		odi <= 1'b0;
		repeat (6) @(posedge pclk);
		apb(1'b0, `DCPCT_OFS_STATUS, 32'h0);
		chk({rd[11], pin_oe}, 9'h100);
		apb(1'b1, `DCPCT_OFS_STATUS, 32'h800);
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		chk(pin_oe, 8'h0f);
		// PWM on pin B; every second event reloads B from the timing table.
		seed = lfsr(seed);
		tbl = '{16'd10, 16'd25, 16'd5 + seed[4:0]};
		apb(1'b1, ca(0, `DCPCT_CH_CNT), 32'h0);
		apb(1'b1, ca(0, `DCPCT_CH_CTRL), 32'h8);
		apb(1'b1, ca(0, `DCPCT_CH_GRA), 32'd40);
		apb(1'b1, `DCPCT_OFS_OUTCFG, 32'h0200);
		apb(1'b1, `DCPCT_OFS_GCTRL, 32'h9);
		for (i = 0; i < 6; i++) begin
			wait_ev;
			apb(1'b1, ca(0, `DCPCT_CH_GRB), {16'h0, tbl[i % 3]});
			wait_ev;
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			chk(hi_width, 16'd40 - tbl[i % 3]);
			chk(ev_gap, 16'd41);
		end
		// Complementary mode raises triggers at crest and trough.
		apb(1'b1, `DCPCT_OFS_GCTRL, 32'h0);
		apb(1'b1, ca(0, `DCPCT_CH_CTRL), 32'h0);
		apb(1'b1, ca(0, `DCPCT_CH_CNT), 32'h0);
		apb(1'b1, ca(0, `DCPCT_CH_GRA), 32'd20);
		apb(1'b1, `DCPCT_OFS_GCTRL, 32'h321);
		repeat (200) @(posedge pclk);
		apb(1'b1, `DCPCT_OFS_GCTRL, 32'h0);
		chk(adc_count >= 16'd4, 1'b1);
		complete_run;
	end
endmodule // test_dual_channel_pwm_capture_timer
`default_nettype wire
